// [common/pid_defs.vh]
/*
 * shared constants of the pid setpoint controller: reset values of the
 * settings, encodings of mode codes and the update tick timing.
 * assumes a 125 MHz clock.
 */
`ifndef PID_DEFS_VH
`define PID_DEFS_VH

// clock period and tick period
`define CLK_PERIOD_PS       8000
`define TICK_TIME_US        7000
// split so the intermediate product stays inside a 32-bit integer
`define TICK_CYCLES         ((`TICK_TIME_US * 1000) / (`CLK_PERIOD_PS / 1000))

// mode codes, one nibble per displayed digit
`define CTRL_MODE_PID       16'h0010
`define PID_ENABLE_CODE     8'h09

// setting limits and reset values (units as commented)
`define TARGET_MAX          16'h9C40
`define TARGET_ONE_RST      16'h1770
`define TARGET_JOG_RST      16'h0258
`define TARGET_OTHER_RST    16'h0000
`define DETECT_GAIN_MIN     16'h0001
`define DETECT_GAIN_MAX     16'h03E8
`define DETECT_GAIN_RST     16'h0064
`define PGAIN_MAX           16'h0064
`define PGAIN_RST           16'h000A
`define ITIME_MAX           16'h03E8
`define ITIME_RST           16'h0064
`define DTIME_MAX           16'h0064
`define DTIME_RST           16'h0000
`define BIAS_MAX            16'h006D
`define BIAS_RST            16'h0000
`define IUPPER_MAX          16'h006D
`define IUPPER_RST          16'h0064
`define FILT_MAX            16'h0019
`define FILT_RST            16'h0000

// full scale of a percent figure in target units (100.00 %)
`define PCT_SCALE           16'h2710

`endif

// [sim/pid_sensor_model.sv]
/*
 * far-side model: feedback sensor and the integral reset contact.
 * assumes the bench sets the sensed level already scaled to target units.
 */
`timescale 1ns/1ps

module pid_sensor_model (
    // clock
    input  wire        mclk,
    // commands from the bench
    input  wire [15:0] level_cmd,
    input  wire        reset_cmd,
    // towards the controller
    output reg  [15:0] feedback,
    output reg         integral_reset_contact
);
    initial feedback = 16'h0000;
    initial integral_reset_contact = 1'b0;
    always @(posedge mclk) begin
        feedback <= level_cmd;
        integral_reset_contact <= reset_cmd;
    end
endmodule // pid_sensor_model

// [sim/pid_setpoint_controller_chk.sv]
/*
 * port assertions of the pid setpoint controller.
 * assumes clk_en held high, inputs synchronous to mclk.
 */
`timescale 1ns/1ps

module pid_setpoint_controller_chk #(
    parameter TICK_COUNT = 875000
) (
    // clock and reset
    input wire        mclk,
    input wire        srst,
    // mode, source and contacts
    input wire [15:0] control_mode_select,
    input wire [7:0]  pid_enable_select,
    input wire        use_stored,
    input wire        pid_cancel_contact,
    input wire [15:0] analog_target,
    // outputs
    input wire [15:0] reference_reg,
    input wire        pid_active_reg,
    input wire        tick_reg
);
    reg [31:0] gap_reg;
    reg        seen_reg;
    // first tick after reset has no reference spacing
    always @(posedge mclk) begin
        gap_reg  <= (srst || tick_reg) ? 32'h1 : gap_reg + 32'h1;
        seen_reg <= srst ? 1'b0 : (seen_reg | tick_reg);
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    AST_RESET: assert property ($fell(srst) |-> reference_reg == 16'h0 && !pid_active_reg && !tick_reg)
        else $error("outputs not cleared by reset");
    AST_ACTIVE: assert property (!$past(srst) |-> pid_active_reg ==
        $past(control_mode_select == 16'h0010 && pid_enable_select == 8'h09 && !pid_cancel_contact))
        else $error("run state does not follow mode code");
    AST_CANCEL: assert property (!$past(srst) && $past(pid_cancel_contact) |-> !pid_active_reg)
        else $error("active while cancel asserted");
    AST_TICK_PULSE: assert property (tick_reg |=> !tick_reg)
        else $error("tick wider than one cycle");
    AST_TICK_GAP: assert property (tick_reg && seen_reg |-> gap_reg == TICK_COUNT)
        else $error("tick spacing wrong");
    AST_BYPASS: assert property ((!use_stored && control_mode_select != 16'h0010 && $stable(analog_target))[*3]
        |-> reference_reg == analog_target)
        else $error("bypass does not pass analog target");
    // reference moves one cycle after the tick pulse, so that cycle is exempt
    AST_QUIET: assert property (pid_active_reg && $past(pid_active_reg) && !$past(tick_reg)
        && $past(pid_active_reg, 2) |-> $stable(reference_reg))
        else $error("pid output moved between ticks");
    AST_RANGE: assert property (reference_reg <= 16'h9C40)
        else $error("reference above full range");
endmodule // pid_setpoint_controller_chk

bind pid_setpoint_controller pid_setpoint_controller_chk #(.TICK_COUNT(TICK_COUNT)) chk (.mclk, .srst,
    .control_mode_select, .pid_enable_select, .use_stored, .pid_cancel_contact, .analog_target,
    .reference_reg, .pid_active_reg, .tick_reg);

// [sim/pid_setpoint_controller_tb.sv]
/*
 * self-checking bench of the pid setpoint controller.
 * assumes a 20-cycle tick and the sensor model on the feedback side.
 */
`timescale 1ns/1ps

module pid_setpoint_controller_tb;
    reg         mclk = 0, srst = 1, clk_en = 1, use_stored = 1, settings_load = 0;
    reg  [15:0] control_mode_select = 16'h0000;
    reg  [7:0]  pid_enable_select = 8'h09;
    reg  [3:0]  reference_source_select = 4'h1;
    reg  [15:0] target_one = 16'h1770, target_two = 16'h0, target_three = 16'h0, target_four = 16'h0;
    reg  [15:0] target_jog = 16'h0258, feedback_detect_gain = 16'h0064, proportional_gain = 16'h000A;
    reg  [15:0] integral_time = 16'h0, derivative_time = 16'h0, output_bias = 16'h0;
    reg  [15:0] integral_upper_bound = 16'h0064, output_delay_constant = 16'h0;
    reg         jog_contact = 0, step1_contact = 0, step2_contact = 0, pid_cancel_contact = 0, reset_cmd = 0;
    reg  [15:0] analog_target = 16'h1234, level_cmd = 16'h03E8, r0;
    wire [15:0] feedback, reference_reg;
    wire        integral_reset_contact, pid_active_reg, tick_reg;
    integer     n_mismatch = 0, comparisons = 0, k;

    always #4 mclk = ~mclk;

    pid_sensor_model sensor (.mclk, .level_cmd, .reset_cmd, .feedback, .integral_reset_contact);
    pid_setpoint_controller #(.TICK_COUNT(20)) dut (.mclk, .srst, .clk_en, .control_mode_select,
        .pid_enable_select, .reference_source_select, .use_stored, .settings_load, .target_one, .target_two,
        .target_three, .target_four, .target_jog, .feedback_detect_gain, .proportional_gain, .integral_time,
        .derivative_time, .output_bias, .integral_upper_bound, .output_delay_constant, .jog_contact,
        .step1_contact, .step2_contact, .integral_reset_contact, .pid_cancel_contact, .analog_target,
        .feedback, .reference_reg, .pid_active_reg, .tick_reg);

    task complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task check(input [15:0] got, input [15:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task step(input integer n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task load;
        settings_load = 1;
        step(1);
        settings_load = 0;
    endtask

    // leaves the bench in the cycle where the new pid output is visible
    task wait_tick;
        integer i;
        step(1);
        for (i = 0; i < 100 && tick_reg !== 1'b1; i = i + 1)
            step(1);
        if (i == 100) begin
            n_mismatch = n_mismatch + 1;
            complete_run;
        end else begin
            // reference follows the tick pulse by one cycle
            step(1);
        end
    endtask

    task t_select;
        for (k = 0; k < 5; k = k + 1) begin
            {step2_contact, step1_contact} = k[1:0];
            jog_contact = (k == 4);
            step(3);
            check(reference_reg, (k == 4) ? 16'h0258 : (k == 0) ? 16'h1770 : 16'h0000);
        end
        jog_contact = 0;
        reference_source_select = 4'h0;
        step(3);
        check(reference_reg, 16'h1234);
        use_stored = 0;
        step(3);
        check(reference_reg, 16'h1234);
        use_stored = 1;
        reference_source_select = 4'h1;
        target_one = 16'hFFFF;
        load;
        step(3);
        check(reference_reg, 16'h9C40);
    endtask

    task t_pbias;
        control_mode_select = 16'h0010;
        target_one = 16'h1770;
        feedback_detect_gain = 16'h00C8;
        output_bias = 16'h0005;
        load;
        wait_tick;
        wait_tick;
        check(reference_reg, 16'h1194);
        check({15'h0, pid_active_reg}, 16'h0001);
    endtask

    task t_integral;
        feedback_detect_gain = 16'h0064;
        output_bias = 16'h0;
        proportional_gain = 16'h0;
        integral_time = 16'h000A;
        load;
        wait_tick;
        r0 = reference_reg;
        wait_tick;
        check(reference_reg, r0 + 16'h0023);
        wait_tick;
        check(reference_reg, r0 + 16'h0046);
        reset_cmd = 1;
        wait_tick;
        check(reference_reg, 16'h0000);
        reset_cmd = 0;
        integral_time = 16'h0001;
        integral_upper_bound = 16'h0001;
        load;
        wait_tick;
        wait_tick;
        check(reference_reg, 16'h0064);
    endtask

    task t_deriv;
        // zero integral time freezes the integrator, so empty it first
        reset_cmd = 1;
        integral_time = 16'h0;
        integral_upper_bound = 16'h0064;
        derivative_time = 16'h0007;
        load;
        reset_cmd = 0;
        wait_tick;
        wait_tick;
        check(reference_reg, 16'h0000);
        level_cmd = 16'h03DE;
        wait_tick;
        check(reference_reg, 16'h0064);
        wait_tick;
        check(reference_reg, 16'h0000);
        derivative_time = 16'h0;
        load;
        level_cmd = 16'h03D4;
        wait_tick;
        check(reference_reg, 16'h0000);
    endtask

    task t_mode;
        proportional_gain = 16'h000A;
        level_cmd = 16'h03E8;
        load;
        control_mode_select = 16'h0011;
        step(3);
        check(reference_reg, 16'h1770);
        control_mode_select = 16'h0010;
        pid_enable_select = 8'h08;
        step(3);
        check(reference_reg, 16'h1770);
        pid_enable_select = 8'h09;
        pid_cancel_contact = 1;
        step(3);
        check(reference_reg, 16'h1770);
        check({15'h0, pid_active_reg}, 16'h0000);
        pid_cancel_contact = 0;
        wait_tick;
        wait_tick;
        check(reference_reg, 16'h1388);
        output_delay_constant = 16'h0001;
        level_cmd = 16'h0000;
        load;
        wait_tick;
        check(reference_reg, 16'h13C9);
    endtask

    initial begin
        step(20);
        srst = 0;
        t_select;
        t_pbias;
        t_integral;
        t_deriv;
        t_mode;
        complete_run;
    end
endmodule // pid_setpoint_controller_tb

// [src/pid_setpoint_controller.v]
/*
 * periodic pid control section: target select, deviation, p/i/d terms on
 * a 7 ms tick, integral clamp, bias, first-order output filter.
 * assumes settings are static inputs held by the surrounding logic,
 * contacts already debounced, all inputs synchronous to mclk.
 */
`timescale 1ns/1ps
`include "pid_defs.vh"

module pid_setpoint_controller #(
    parameter W          = 16,
    parameter ACC_W      = 48,
    parameter TICK_COUNT = `TICK_CYCLES
) (
    // clock, reset, enable
    input  wire          mclk,
    input  wire          srst,
    input  wire          clk_en,
    // mode settings
    input  wire [15:0]   control_mode_select,
    input  wire [7:0]    pid_enable_select,
    input  wire [3:0]    reference_source_select,
    input  wire          use_stored,
    // settings loading (value captured when load is high)
    input  wire          settings_load,
    input  wire [W-1:0]  target_one,
    input  wire [W-1:0]  target_two,
    input  wire [W-1:0]  target_three,
    input  wire [W-1:0]  target_four,
    input  wire [W-1:0]  target_jog,
    input  wire [W-1:0]  feedback_detect_gain,
    input  wire [W-1:0]  proportional_gain,
    input  wire [W-1:0]  integral_time,
    input  wire [W-1:0]  derivative_time,
    input  wire [W-1:0]  output_bias,
    input  wire [W-1:0]  integral_upper_bound,
    input  wire [W-1:0]  output_delay_constant,
    // contacts
    input  wire          jog_contact,
    input  wire          step1_contact,
    input  wire          step2_contact,
    input  wire          integral_reset_contact,
    input  wire          pid_cancel_contact,
    // analog samples, target units
    input  wire [W-1:0]  analog_target,
    input  wire [W-1:0]  feedback,
    // outputs
    output reg  [W-1:0]  reference_reg,
    output reg           pid_active_reg,
    output reg           tick_reg
);

    // stored settings
    reg [W-1:0] t1_reg, t2_reg, t3_reg, t4_reg, tj_reg;
    reg [W-1:0] dgain_reg, pgain_reg, itime_reg, dtime_reg;
    reg [W-1:0] bias_reg, iup_reg, filt_reg;

    // saturating range check of a setting
    function [W-1:0] lim;
        input [W-1:0] v;
        input [W-1:0] lo;
        input [W-1:0] hi;
        begin
            lim = (v < lo) ? lo : ((v > hi) ? hi : v);
        end
    endfunction

    // clamp a signed wide value into +-bound
    function signed [ACC_W-1:0] clampw;
        input signed [ACC_W-1:0] v;
        input signed [ACC_W-1:0] b;
        begin
            clampw = (v > b) ? b : ((v < -b) ? -b : v);
        end
    endfunction

    always @(posedge mclk) begin
        if (srst) begin
            t1_reg    <= `TARGET_ONE_RST;
            t2_reg    <= `TARGET_OTHER_RST;
            t3_reg    <= `TARGET_OTHER_RST;
            t4_reg    <= `TARGET_OTHER_RST;
            tj_reg    <= `TARGET_JOG_RST;
            dgain_reg <= `DETECT_GAIN_RST;
            pgain_reg <= `PGAIN_RST;
            itime_reg <= `ITIME_RST;
            dtime_reg <= `DTIME_RST;
            bias_reg  <= `BIAS_RST;
            iup_reg   <= `IUPPER_RST;
            filt_reg  <= `FILT_RST;
        end else if (clk_en && settings_load) begin
            t1_reg    <= lim(target_one, 16'h0000, `TARGET_MAX);
            t2_reg    <= lim(target_two, 16'h0000, `TARGET_MAX);
            t3_reg    <= lim(target_three, 16'h0000, `TARGET_MAX);
            t4_reg    <= lim(target_four, 16'h0000, `TARGET_MAX);
            tj_reg    <= lim(target_jog, 16'h0000, `TARGET_MAX);
            dgain_reg <= lim(feedback_detect_gain, `DETECT_GAIN_MIN, `DETECT_GAIN_MAX);
            pgain_reg <= lim(proportional_gain, 16'h0000, `PGAIN_MAX);
            itime_reg <= lim(integral_time, 16'h0000, `ITIME_MAX);
            dtime_reg <= lim(derivative_time, 16'h0000, `DTIME_MAX);
            bias_reg  <= lim(output_bias, 16'h0000, `BIAS_MAX);
            iup_reg   <= lim(integral_upper_bound, 16'h0000, `IUPPER_MAX);
            filt_reg  <= lim(output_delay_constant, 16'h0000, `FILT_MAX);
        end
    end

    wire [W-1:0] target;

    pid_target_select #(
        .W (W)
    ) u_sel (
        .mclk                    (mclk),
        .srst                    (srst),
        .clk_en                  (clk_en),
        .use_stored              (use_stored),
        .reference_source_select (reference_source_select),
        .jog_contact             (jog_contact),
        .step1_contact           (step1_contact),
        .step2_contact           (step2_contact),
        .analog_target           (analog_target),
        .target_one              (t1_reg),
        .target_two              (t2_reg),
        .target_three            (t3_reg),
        .target_four             (t4_reg),
        .target_jog              (tj_reg),
        .target_reg              (target)
    );

    // mode gate
    wire run = (control_mode_select == `CTRL_MODE_PID) && (pid_enable_select == `PID_ENABLE_CODE);

    // tick counter
    reg [31:0] tick_cnt_reg;
    wire       tick_hit = (tick_cnt_reg == TICK_COUNT - 1);

    always @(posedge mclk) begin
        if (srst) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg     <= 1'b0;
        end else if (clk_en) begin
            tick_cnt_reg <= tick_hit ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
            tick_reg     <= tick_hit;
        end
    end

    // deviation: gain is in 0.01 steps; feedback range 0-10 V / 4-20 mA is
    // assumed already converted to target units upstream
    wire [2*W-1:0]          fb_scaled = feedback * dgain_reg;
    wire signed [ACC_W-1:0] fb_w      = $signed({{(ACC_W-2*W){1'b0}}, fb_scaled}) / 100;
    wire signed [ACC_W-1:0] dev       = $signed({{(ACC_W-W){1'b0}}, target}) - fb_w;

    // pid state, updated per tick; integral kept scaled by 1000 for resolution
    reg signed [ACC_W-1:0] integ_reg;
    reg signed [ACC_W-1:0] dev_prev_reg;
    reg signed [ACC_W-1:0] filt_out_reg;

    wire signed [ACC_W-1:0] pgain_w  = $signed({{(ACC_W-W){1'b0}}, pgain_reg});
    wire signed [ACC_W-1:0] itime_w  = $signed({{(ACC_W-W){1'b0}}, itime_reg});
    wire signed [ACC_W-1:0] dtime_w  = $signed({{(ACC_W-W){1'b0}}, dtime_reg});
    wire signed [ACC_W-1:0] iup_w    = $signed({{(ACC_W-W){1'b0}}, iup_reg});
    wire signed [ACC_W-1:0] bias_w   = $signed({{(ACC_W-W){1'b0}}, bias_reg});
    wire signed [ACC_W-1:0] filt_w   = $signed({{(ACC_W-W){1'b0}}, filt_reg});

    // p: gain in 0.1 steps
    wire signed [ACC_W-1:0] p_term = (dev * pgain_w) / 10;

    // i increment = dev * 7 ms / (itime * 100 ms); kept x1000
    // zero integral time leaves the integrator frozen rather than dividing by zero
    wire signed [ACC_W-1:0] i_inc  = (itime_reg == 16'h0000) ? {ACC_W{1'b0}} :
                                     (dev * 70) / itime_w;
    wire signed [ACC_W-1:0] i_bnd  = (iup_w * $signed({{(ACC_W-W){1'b0}}, `PCT_SCALE})) * 10;
    wire signed [ACC_W-1:0] i_term = integ_reg / 1000;

    // d: (dev - prev) * dtime(10 ms units) / 7 ms
    wire signed [ACC_W-1:0] d_term = (dtime_reg == 16'h0000) ? {ACC_W{1'b0}} :
                                     ((dev - dev_prev_reg) * dtime_w * 10) / 7;

    // bias percent of full scale
    wire signed [ACC_W-1:0] bias_v = (bias_w * $signed({{(ACC_W-W){1'b0}}, `PCT_SCALE})) / 100;
    wire signed [ACC_W-1:0] sum    = p_term + i_term + d_term + bias_v;

    // filter: alpha = 7 ms / (T + 7 ms), T in 100 ms units
    wire signed [ACC_W-1:0] filt_nx = (filt_reg == 16'h0000) ? sum :
                                      filt_out_reg + ((sum - filt_out_reg) * 7) / (filt_w * 100 + 7);

    always @(posedge mclk) begin
        if (srst) begin
            integ_reg    <= {ACC_W{1'b0}};
            dev_prev_reg <= {ACC_W{1'b0}};
            filt_out_reg <= {ACC_W{1'b0}};
        end else if (clk_en) begin
            if (!run || integral_reset_contact) begin
                integ_reg <= {ACC_W{1'b0}};
            end else if (tick_hit) begin
                integ_reg <= clampw(integ_reg + i_inc, i_bnd);
            end
            if (tick_hit) begin
                dev_prev_reg <= dev;
                filt_out_reg <= run ? filt_nx : {ACC_W{1'b0}};
            end
        end
    end

    // output saturation to target range
    wire [W-1:0] pid_out = (filt_out_reg < 0) ? {W{1'b0}} :
                           (filt_out_reg > $signed({{(ACC_W-W){1'b0}}, `TARGET_MAX})) ? `TARGET_MAX :
                           filt_out_reg[W-1:0];

    always @(posedge mclk) begin
        if (srst) begin
            reference_reg  <= {W{1'b0}};
            pid_active_reg <= 1'b0;
        end else if (clk_en) begin
            pid_active_reg <= run && !pid_cancel_contact;
            if (!run || pid_cancel_contact) begin
                reference_reg <= target;
            end else begin
                reference_reg <= pid_out;
            end
        end
    end

endmodule // pid_setpoint_controller

// [src/pid_target_select.v]
/*
 * target selection: picks the active target from the analog input or the
 * stored settings, using the jog and multi-step contacts.
 * assumes contacts and settings are synchronous to mclk.
 */
`timescale 1ns/1ps
`include "pid_defs.vh"

module pid_target_select #(
    parameter W = 16
) (
    // clock and control
    input  wire         mclk,
    input  wire         srst,
    input  wire         clk_en,
    // source selection
    input  wire         use_stored,
    input  wire [3:0]   reference_source_select,
    input  wire         jog_contact,
    input  wire         step1_contact,
    input  wire         step2_contact,
    // candidates
    input  wire [W-1:0] analog_target,
    input  wire [W-1:0] target_one,
    input  wire [W-1:0] target_two,
    input  wire [W-1:0] target_three,
    input  wire [W-1:0] target_four,
    input  wire [W-1:0] target_jog,
    // result
    output reg  [W-1:0] target_reg
);

    reg [W-1:0] target_next;
    reg [W-1:0] first_src;

    always @* begin
        // lowest digit 0 replaces target one by the analog input
        first_src = reference_source_select[0] ? target_one : analog_target;
        if (!use_stored) begin
            target_next = analog_target;
        end else if (jog_contact) begin
            target_next = target_jog;
        end else begin
            case ({step2_contact, step1_contact})
                2'b00:   target_next = first_src;
                2'b01:   target_next = target_two;
                2'b10:   target_next = target_three;
                default: target_next = target_four;
            endcase
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            target_reg <= {W{1'b0}};
        end else if (clk_en) begin
            target_reg <= target_next;
        end
    end

endmodule // pid_target_select
